/* inc/cbs_pkg.sv */
// Shared constants for the block sync and output port
package cbs_pkg;
   localparam int          DATA_W        = 8;
   localparam int          CNT_W         = 16;
   localparam int          APB_AW        = 8;
   // Register offsets
   localparam logic [7:0]  OFS_CTRL      = 8'h00;
   localparam logic [7:0]  OFS_SYNC      = 8'h04;
   localparam logic [7:0]  OFS_BLKLEN    = 8'h08;
   localparam logic [7:0]  OFS_STATUS    = 8'h0c;
   localparam logic [7:0]  OFS_MASK      = 8'h10;
   localparam logic [7:0]  OFS_CORR      = 8'h14;
   localparam logic [7:0]  OFS_STATE     = 8'h18;
   // Control fields
   localparam int          CTRL_ENABLE   = 0;
   localparam int          CTRL_DECODE   = 1;
   localparam int          CTRL_PARSEL   = 2;
   localparam int          CTRL_RESYNC   = 3;
   // Sync fields
   localparam int          SYNC_LEN_LSB  = 0;
   localparam int          SYNC_INT_LSB  = 4;
   // Status and mask bits
   localparam int          ST_MISS       = 0;
   localparam int          ST_CORR_INCREASE_FLAG     = 1;
   localparam int          ST_W          = 2;
   // Reset values
   localparam logic [2:0]  CTRL_RST      = 3'h0;
   localparam logic [7:0]  SYNC_RST      = 8'h00;
   localparam logic [15:0] BLKLEN_RST    = 16'h1000;
   localparam logic [1:0]  MASK_RST      = 2'h0;

   typedef enum {
      ST_OFF,
      ST_HUNT,
      ST_DATA,
      ST_STRIP,
      ST_CHECK
   } cbs_state_e;
endpackage : cbs_pkg

/* inc/cbs_link_if.sv */
// Link between the codec port and the far party
`timescale 1ns/1ps
interface cbs_link_if;
   logic [7:0] in_data;
   logic       in_sync;
   logic       in_ready;
   logic       in_accept;
   logic [7:0] out_data;
   logic       out_sync;
   logic       out_ready;
   logic       out_accept;

   modport dev (
      input  in_data, in_sync, in_ready, out_accept,
      output in_accept, out_data, out_sync, out_ready
   );
   modport far (
      output in_data, in_sync, in_ready, out_accept,
      input  in_accept, out_data, out_sync, out_ready
   );
endinterface : cbs_link_if

/* logic/cbs_dev_end.sv */
// Codec block sync, mark stripping and output port
//
// Chosen here: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
module cbs_dev_end
   import cbs_pkg::*;
(
   // Clock and reset
   input  wire logic                         i_core_clk,
   input  wire logic                         i_srst,
   // APB slave
   input  wire logic                         i_psel,
   input  wire logic                         i_penable,
   input  wire logic                         i_pwrite,
   input  wire logic [cbs_pkg::APB_AW-1:0]   i_paddr,
   input  wire logic [31:0]                  i_pwdata,
   output logic      [31:0]                  o_prdata,
   output logic                              o_pready,
   output logic                              o_pslverr,
   // Link
   cbs_link_if.dev                           lnk,
   // Words toward the coder core
   output logic      [cbs_pkg::DATA_W-1:0]   o_core_data,
   output logic                              o_core_first,
   output logic                              o_core_valid,
   input  wire logic                         i_core_ready,
   // Words from the output buffer
   input  wire logic [cbs_pkg::DATA_W-1:0]   i_blk_data,
   input  wire logic                         i_blk_first,
   input  wire logic                         i_blk_valid,
   output logic                              o_blk_ready,
   // Decoder status
   input  wire logic [9:0]                   i_corr_count,
   input  wire logic                         i_corr_inc,
   // Mode and interrupt
   output logic                              o_enable,
   output logic                              o_decode,
   output logic                              o_irq
);
   import cbs_pkg::*;
   logic [2:0]       ctrl_reg;
   logic [7:0]       sync_reg;
   logic [CNT_W-1:0] blklen_reg;
   logic [ST_W-1:0]  status_reg;
   logic [ST_W-1:0]  mask_reg;
   logic [31:0]      prdata_reg;
   logic             resync_reg;
   cbs_state_e       st_reg;
   logic [CNT_W-1:0] word_reg;
   logic [3:0]       blk_reg;
   logic [5:0]       strip_reg;
   logic             miss_pulse;
   logic [DATA_W-1:0] cdata_reg;
   logic             cfirst_reg;
   logic             cvalid_reg;
   logic [DATA_W-1:0] out_data_reg;
   logic             out_sync_reg;
   logic             ovalid_reg;
   logic [3:0]       oblk_reg;
   logic             wr_en;
   logic             setup_rd;
   logic             take;
   logic             fwd;
   logic             fwd_first;
   logic             blk_end;
   logic             load;
   logic             serial;
   logic [3:0]       mark_len;
   logic [3:0]       mark_int;
   logic [5:0]       strip_last;
   logic             mapped;
   assign mark_len   = sync_reg[SYNC_LEN_LSB +: 4];
   assign mark_int   = sync_reg[SYNC_INT_LSB +: 4];
   assign strip_last = {mark_len, 2'b00} - 6'h01;
   assign o_enable   = ctrl_reg[CTRL_ENABLE];
   assign o_decode   = ctrl_reg[CTRL_DECODE];
   // APB decode
   assign wr_en     = i_psel & i_penable & i_pwrite;
   assign setup_rd  = i_psel & ~i_penable & ~i_pwrite;
   assign mapped    = (i_paddr == OFS_CTRL) | (i_paddr == OFS_SYNC) | (i_paddr == OFS_BLKLEN) |
                      (i_paddr == OFS_STATUS) | (i_paddr == OFS_MASK) | (i_paddr == OFS_CORR) |
                      (i_paddr == OFS_STATE);
   assign o_pready  = 1'b1;
   assign o_pslverr = i_psel & i_penable & ~mapped;
   assign o_prdata  = prdata_reg;
   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         ctrl_reg   <= CTRL_RST;
         sync_reg   <= SYNC_RST;
         blklen_reg <= BLKLEN_RST;
         mask_reg   <= MASK_RST;
      end else if (wr_en) begin
         if (i_paddr == OFS_CTRL) ctrl_reg <= i_pwdata[2:0];
         if (i_paddr == OFS_SYNC) sync_reg <= i_pwdata[7:0];
         if (i_paddr == OFS_BLKLEN) blklen_reg <= i_pwdata[CNT_W-1:0];
         if (i_paddr == OFS_MASK) mask_reg <= i_pwdata[ST_W-1:0];
      end
   end
   always_ff @(posedge i_core_clk) begin
      if (i_srst) resync_reg <= 1'b0;
      else resync_reg <= wr_en & (i_paddr == OFS_CTRL) & i_pwdata[CTRL_RESYNC];
   end
   always_ff @(posedge i_core_clk) begin
      if (i_srst) prdata_reg <= 32'h0;
      else if (setup_rd) begin
         unique case (i_paddr)
            OFS_CTRL:   prdata_reg <= {29'h0, ctrl_reg};
            OFS_SYNC:   prdata_reg <= {24'h0, sync_reg};
            OFS_BLKLEN: prdata_reg <= {16'h0, blklen_reg};
            OFS_STATUS: prdata_reg <= {30'h0, status_reg};
            OFS_MASK:   prdata_reg <= {30'h0, mask_reg};
            OFS_CORR:   prdata_reg <= {22'h0, i_corr_count};
            OFS_STATE:  prdata_reg <= {29'h0, st_reg == ST_HUNT, st_reg == ST_STRIP, st_reg == ST_CHECK};
            default:    prdata_reg <= 32'h0;
         endcase
      end
   end
   always_ff @(posedge i_core_clk) begin
      if (i_srst) status_reg <= '0;
      else begin
         status_reg <= (status_reg & ~((wr_en && i_paddr == OFS_STATUS) ? i_pwdata[ST_W-1:0] : '0))
                       | {i_corr_inc, miss_pulse};
      end
   end
   assign o_irq = |(status_reg & mask_reg);
   // Accept once enabled and core can take a word
   assign lnk.in_accept = o_enable & (st_reg != ST_OFF) & (~cvalid_reg | i_core_ready);
   // Data and sync taken on the same handshake
   assign take = lnk.in_ready & lnk.in_accept & ~resync_reg;
   assign blk_end = (word_reg == blklen_reg - 16'h0001);
   always_comb begin
      fwd       = 1'b0;
      fwd_first = 1'b0;
      miss_pulse = 1'b0;
      if (take) begin
         unique case (st_reg)
            // Hunt forwards only the sync word
            ST_HUNT: begin
               fwd       = lnk.in_sync;
               fwd_first = 1'b1;
            end
            ST_DATA: begin
               fwd       = 1'b1;
               fwd_first = (word_reg == '0);
            end
            // Sync must sit on the first kept word
            ST_CHECK: begin
               fwd        = 1'b1;
               fwd_first  = 1'b1;
               miss_pulse = ~lnk.in_sync;
            end
            ST_STRIP, ST_OFF: fwd = 1'b0;
         endcase
      end
   end
   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         st_reg    <= ST_OFF;
         word_reg  <= '0;
         blk_reg   <= 4'h0;
         strip_reg <= 6'h00;
      end else if (!o_enable) begin
         st_reg <= ST_OFF;
      end else if (st_reg == ST_OFF || (resync_reg && o_decode)) begin
         // Resync restarts the hunt for sync
         st_reg    <= o_decode ? ST_HUNT : ST_DATA;
         word_reg  <= '0;
         blk_reg   <= 4'h0;
         strip_reg <= 6'h00;
      end else if (take) begin
         unique case (st_reg)
            ST_HUNT: begin
               if (lnk.in_sync) begin
                  st_reg   <= ST_DATA;
                  word_reg <= 16'h0001;
               end
            end
            ST_DATA, ST_CHECK: begin
               st_reg   <= ST_DATA;
               word_reg <= (st_reg == ST_CHECK) ? 16'h0001 : word_reg + 16'h0001;
               if (st_reg == ST_DATA && blk_end) begin
                  word_reg <= '0;
                  if (o_decode && mark_int != 4'h0) begin
                     if (blk_reg + 4'h1 == mark_int) begin
                        blk_reg <= 4'h0;
                        st_reg  <= (mark_len != 4'h0) ? ST_STRIP : ST_CHECK;
                     end else begin
                        blk_reg <= blk_reg + 4'h1;
                     end
                  end
               end
            end
            // Drop four words per mark_len unit
            ST_STRIP: begin
               if (strip_reg == strip_last) begin
                  strip_reg <= 6'h00;
                  st_reg    <= ST_CHECK;
               end else begin
                  strip_reg <= strip_reg + 6'h01;
               end
            end
            ST_OFF: st_reg <= ST_OFF;
         endcase
      end
   end
   // Word register toward the core
   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         cvalid_reg <= 1'b0;
         cdata_reg  <= '0;
         cfirst_reg <= 1'b0;
      end else if (fwd) begin
         cvalid_reg <= 1'b1;
         cdata_reg  <= lnk.in_data;
         cfirst_reg <= fwd_first;
      end else if (i_core_ready) begin
         cvalid_reg <= 1'b0;
      end
   end
   assign o_core_data  = cdata_reg;
   assign o_core_first = cfirst_reg;
   assign o_core_valid = cvalid_reg;
   // Output side runs independent of resync
   // Word leaves on ready and accept
   assign lnk.out_ready = ovalid_reg;
   assign o_blk_ready   = ~ovalid_reg | lnk.out_accept;
   assign load          = i_blk_valid & o_blk_ready;
   // Serial unless decode with byte select
   assign serial        = ~o_decode | ~ctrl_reg[CTRL_PARSEL];
   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         ovalid_reg <= 1'b0;
         out_data_reg  <= '0;
         out_sync_reg  <= 1'b0;
      end else if (load) begin
         ovalid_reg <= 1'b1;
         out_data_reg  <= serial ? {7'h00, i_blk_data[0]} : i_blk_data;
         // Every decoded block start; every Nth encoded
         out_sync_reg  <= o_decode ? i_blk_first : (i_blk_first && oblk_reg == 4'h0 && mark_int != 4'h0);
      end else if (lnk.out_accept) begin
         ovalid_reg <= 1'b0;
      end
   end
   // Output block counter for encode marks
   always_ff @(posedge i_core_clk) begin
      if (i_srst || !o_enable) oblk_reg <= 4'h0;
      else if (load && i_blk_first) oblk_reg <= (oblk_reg + 4'h1 >= mark_int) ? 4'h0 : oblk_reg + 4'h1;
   end
   assign lnk.out_data = out_data_reg;
   assign lnk.out_sync = out_sync_reg;
endmodule : cbs_dev_end

/* logic/cbs_far_end.sv */
// Far party: feeds soft data with sync, receives output words
`timescale 1ns/1ps
module cbs_far_end
   import cbs_pkg::*;
(
   // Clock and reset
   input  wire logic                         i_core_clk,
   input  wire logic                         i_srst,
   // Options
   input  wire logic                         i_sync_used,
   // Transmit words
   input  wire logic [cbs_pkg::DATA_W-1:0]   i_tx_data,
   input  wire logic                         i_tx_sync,
   input  wire logic                         i_tx_valid,
   output logic                              o_tx_ready,
   // Received words
   output logic      [cbs_pkg::DATA_W-1:0]   o_rx_data,
   output logic                              o_rx_sync,
   output logic                              o_rx_valid,
   input  wire logic                         i_rx_ready,
   // Link
   cbs_link_if.far                           lnk
);
   import cbs_pkg::*;

   logic [DATA_W-1:0] tdata_reg;
   logic              tsync_reg;
   logic              tvalid_reg;
   logic [DATA_W-1:0] rdata_reg;
   logic              rsync_reg;
   logic              rvalid_reg;
   logic              rtake;

   // Word and sync held until accepted
   assign o_tx_ready = ~tvalid_reg | lnk.in_accept;
   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         tvalid_reg <= 1'b0;
         tdata_reg  <= '0;
         tsync_reg  <= 1'b0;
      end else if (i_tx_valid && o_tx_ready) begin
         tvalid_reg <= 1'b1;
         tdata_reg  <= i_tx_data;
         tsync_reg  <= i_tx_sync;
      end else if (lnk.in_accept) begin
         tvalid_reg <= 1'b0;
      end
   end
   assign lnk.in_ready = tvalid_reg;
   assign lnk.in_data  = tdata_reg;
   // Sync held high when not used
   assign lnk.in_sync  = i_sync_used ? tsync_reg : 1'b1;

   // Take word on ready and accept
   assign lnk.out_accept = ~rvalid_reg | i_rx_ready;
   assign rtake          = lnk.out_ready & lnk.out_accept;
   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         rvalid_reg <= 1'b0;
         rdata_reg  <= '0;
         rsync_reg  <= 1'b0;
      end else if (rtake) begin
         rvalid_reg <= 1'b1;
         rdata_reg  <= lnk.out_data;
         rsync_reg  <= lnk.out_sync;
      end else if (i_rx_ready) begin
         rvalid_reg <= 1'b0;
      end
   end
   assign o_rx_data  = rdata_reg;
   assign o_rx_sync  = rsync_reg;
   assign o_rx_valid = rvalid_reg;
endmodule : cbs_far_end

/* bench/cbs_link_assertions.sv */
// Link handshake checks between the two codec port ends
`timescale 1ns/1ps
module cbs_link_assertions (
   // Clock and reset
   input wire logic       i_core_clk,
   input wire logic       i_srst,
   // Input link
   input wire logic [7:0] i_in_data,
   input wire logic       i_in_sync,
   input wire logic       i_in_ready,
   input wire logic       i_in_accept,
   // Output link
   input wire logic [7:0] i_out_data,
   input wire logic       i_out_sync,
   input wire logic       i_out_ready,
   input wire logic       i_out_accept
);
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_srst);

   a_out_ready_held: assert property (i_out_ready && !i_out_accept |=> i_out_ready)
      else $error("out_ready dropped before accept");
   a_out_data_stable: assert property (i_out_ready && !i_out_accept |=> $stable(i_out_data))
      else $error("out_data changed while waiting");
   a_out_sync_stable: assert property (i_out_ready && $past(i_out_ready && !i_out_accept) |-> i_out_sync == $past(i_out_sync))
      else $error("out_sync changed while waiting");
   a_in_ready_held: assert property (i_in_ready && !i_in_accept |=> i_in_ready)
      else $error("in_ready dropped before accept");
   a_in_word_stable: assert property (i_in_ready && !i_in_accept |=> $stable({i_in_sync, i_in_data}))
      else $error("input word changed while waiting");
   a_reset_out_idle: assert property ($fell(i_srst) |-> !i_out_ready)
      else $error("out_ready high after reset");
   a_reset_no_accept: assert property ($fell(i_srst) |-> (!i_in_accept)[*3])
      else $error("in_accept high before configuration");
   a_reset_in_idle: assert property ($fell(i_srst) |-> !i_in_ready)
      else $error("in_ready high after reset");
endmodule : cbs_link_assertions

/* bench/codec_block_sync_output_port_tb.sv */
// Bench joining both codec port ends over the link
`timescale 1ns/1ps
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin \
   $display("[FAIL] %s exp %0h got %0h", n, e, s); n_errors++; end end
module codec_block_sync_output_port_tb;
   import cbs_pkg::*;
   logic clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
   logic [7:0] paddr = 0, core_data, blk_data = 0, tx_data = 0, rx_data;
   logic [31:0] pwdata = 0, prdata;
   logic core_first, core_valid, core_ready = 0, blk_first = 0, blk_valid = 0, blk_ready;
   logic [9:0] corr_count = 0;
   logic corr_inc = 0, enable, decode, irq, tx_sync = 0, tx_valid = 0, tx_ready;
   logic rx_sync, rx_valid, rx_ready = 0, sync_used = 1;
   logic [8:0] rxq[$], cq[$];
   int n_errors = 0, cmp_count = 0, cyc = 0, rr;
   int seed = 32'h1822;
   cbs_link_if lnk ();
   cbs_dev_end i_cbs_dev_end (.i_core_clk(clk), .i_srst(srst), .i_psel(psel), .i_penable(penable),
      .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
      .o_pslverr(pslverr), .lnk(lnk), .o_core_data(core_data), .o_core_first(core_first),
      .o_core_valid(core_valid), .i_core_ready(core_ready), .i_blk_data(blk_data), .i_blk_first(blk_first),
      .i_blk_valid(blk_valid), .o_blk_ready(blk_ready), .i_corr_count(corr_count), .i_corr_inc(corr_inc),
      .o_enable(enable), .o_decode(decode), .o_irq(irq));
   cbs_far_end i_cbs_far_end (.i_core_clk(clk), .i_srst(srst), .i_sync_used(sync_used), .i_tx_data(tx_data),
      .i_tx_sync(tx_sync), .i_tx_valid(tx_valid), .o_tx_ready(tx_ready), .o_rx_data(rx_data),
      .o_rx_sync(rx_sync), .o_rx_valid(rx_valid), .i_rx_ready(rx_ready), .lnk(lnk));
   cbs_link_assertions i_cbs_link_assertions (.i_core_clk(clk), .i_srst(srst), .i_in_data(lnk.in_data),
      .i_in_sync(lnk.in_sync), .i_in_ready(lnk.in_ready), .i_in_accept(lnk.in_accept),
      .i_out_data(lnk.out_data), .i_out_sync(lnk.out_sync), .i_out_ready(lnk.out_ready),
      .i_out_accept(lnk.out_accept));

   initial begin
      forever #50 clk = ~clk;
   end

   // Collect words, stall both sinks at random, cut hangs
   always @(posedge clk) begin
      if (rx_valid && rx_ready) rxq.push_back({rx_sync, rx_data});
      if (core_valid && core_ready) cq.push_back({core_first, core_data});
      rr = $random(seed);
      rx_ready <= rr[0];
      core_ready <= rr[1];
      cyc++;
      if (cyc > 20000) begin
         n_errors++;
         end_of_test();
      end
   end

   function automatic logic [8:0] exp_out(logic [7:0] d, logic ser, logic syn);
      return {syn, ser ? {7'h0, d[0]} : d};
   endfunction : exp_out

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
                      output logic e);
      psel <= 1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 0;
      @(posedge clk) penable <= 1;
      do @(posedge clk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 0; penable <= 0;
      @(posedge clk);
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1, a, d, r, e);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
      logic [31:0] r;
      logic e;
      apb(0, a, 0, r, e);
      `CHK("prdata", x, r)
      `CHK("pslverr", xe, e)
   endtask : rd

   task automatic tx(input logic [7:0] d, input logic s);
      tx_valid <= 1; tx_data <= d; tx_sync <= s;
      do @(posedge clk); while (tx_ready !== 1'b1);
   endtask : tx

   task automatic blk(input logic [7:0] d, input logic f);
      blk_valid <= 1; blk_data <= d; blk_first <= f;
      do @(posedge clk); while (blk_ready !== 1'b1);
   endtask : blk

   // Output port in one mode, six blocks of two words
   task automatic otest(input logic [2:0] c, input int iv);
      logic [7:0] d;
      logic [8:0] q[$];
      rxq = {};
      wr(OFS_SYNC, iv << 4);
      wr(OFS_CTRL, {29'h0, c});
      for (int b = 0; b < 6; b++) begin
         for (int w = 0; w < 2; w++) begin
            d = $random(seed);
            blk(d, w == 0);
            q.push_back(exp_out(d, !(c[1] && c[2]), w == 0 && (c[1] || (iv != 0 && b % iv == 0))));
         end
      end
      blk_valid <= 0;
      for (int t = 0; t < 200 && rxq.size() < 12; t++) @(posedge clk);
      `CHK("out count", 12, rxq.size())
      foreach (q[i]) `CHK("out word", q[i], rxq[i])
      wr(OFS_CTRL, 0);
   endtask : otest

   // Input words: hunt, strip marks, check sync, blocks of two
   task automatic feed(input logic [15:0] sy, input logic [15:0] kp, input int n);
      logic [7:0] d;
      logic [8:0] q[$];
      int k;
      k = 0;
      cq = {};
      for (int i = 0; i < n; i++) begin
         d = $random(seed);
         tx(d, sy[i]);
         if (kp[i]) begin
            q.push_back({k % 2 == 0, d});
            k++;
         end
      end
      tx_valid <= 0;
      for (int t = 0; t < 200 && cq.size() < q.size(); t++) @(posedge clk);
      `CHK("core count", q.size(), cq.size())
      foreach (q[i]) `CHK("core word", q[i], cq[i])
   endtask : feed

   task end_of_test;
      if (n_errors == 0 && cmp_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : end_of_test

   initial begin
      repeat (6) @(posedge clk);
      srst <= 0;
      @(posedge clk);
      rd(OFS_CTRL, 0, 0);
      rd(OFS_SYNC, 0, 0);
      rd(OFS_BLKLEN, 32'h1000, 0);
      rd(OFS_STATUS, 0, 0);
      rd(OFS_MASK, 0, 0);
      rd(8'h1c, 0, 1);
      otest(3'h1, 3);
      otest(3'h7, 1);
      otest(3'h3, 0);
      wr(OFS_BLKLEN, 2);
      wr(OFS_SYNC, 32'h11);
      wr(OFS_CTRL, 3);
      `CHK("mode", 2'b11, {decode, enable})
      rd(OFS_STATE, 4, 0);
      feed(16'h4004, 16'hc30c, 16);
      corr_count <= 10'($random(seed));
      corr_inc <= 1;
      @(posedge clk) corr_inc <= 0;
      rd(OFS_CORR, {22'h0, corr_count}, 0);
      rd(OFS_STATUS, 3, 0);
      `CHK("irq masked", 1'b0, irq)
      wr(OFS_MASK, 1);
      `CHK("irq raised", 1'b1, irq)
      wr(OFS_STATUS, 1);
      rd(OFS_STATUS, 2, 0);
      `CHK("irq cleared", 1'b0, irq)
      wr(OFS_CTRL, 32'hb);
      rd(OFS_CTRL, 3, 0);
      rd(OFS_STATE, 4, 0);
      feed(16'h0004, 16'h000c, 4);
      // Sync unused: far end holds it high, hunt takes first word
      sync_used <= 0;
      wr(OFS_CTRL, 32'hb);
      feed(16'h0000, 16'h00c3, 8);
      rd(OFS_STATUS, 2, 0);
      // Missed mark after clearing sets the flag again
      sync_used <= 1;
      feed(16'h0000, 16'h0030, 6);
      rd(OFS_STATUS, 3, 0);
      `CHK("irq again", 1'b1, irq)
      end_of_test();
   end
endmodule : codec_block_sync_output_port_tb
